// [sim/data_transfer_instruction_unit_tb.sv]
`timescale 1ns/1ps
`include "dtu_params.svh"

`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %0t got %h exp %h", $time, (a), (e)); end end

module data_transfer_instruction_unit_tb;
  localparam logic [3:0] imm = 4'h1, st = 4'h2, ld = 4'h3, ioi = 4'h4;
  localparam logic [3:0] ioo = 4'h5, tw = 4'h6, wt = 4'h7, xl = 4'h8;
  localparam logic [3:0] xs = 4'h9, bs = 4'ha, bc = 4'hb;

  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [3:0]  instr_op = 4'h0;
  logic [7:0]  instr_operand = 8'h00;
  logic [2:0]  instr_bit = 3'h0;
  logic        instr_ready;
  logic [7:0]  io_rdata = 8'h00;
  logic [7:0]  io_port_byte;
  logic [7:0]  io_wdata;
  logic        io_we;
  logic [15:0] timer_count = 16'h0000;
  logic        timer_load;
  logic [15:0] timer_load_value;
  logic [7:0]  bus_addr = 8'h00;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_we = 1'b0;
  logic        bus_re = 1'b0;
  logic [7:0]  bus_rdata;
  logic [7:0]  work_register;
  logic [3:0]  flags;
  logic        bit_fault;
  logic [7:0]  d;
  int          error_cnt = 0;
  int          n_checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  data_transfer_instruction_unit data_transfer_instruction_unit_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_operand(instr_operand),
    .instr_bit(instr_bit), .instr_ready(instr_ready),
    .io_rdata(io_rdata), .io_port_byte(io_port_byte),
    .io_wdata(io_wdata), .io_we(io_we), .timer_count(timer_count),
    .timer_load(timer_load), .timer_load_value(timer_load_value),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
    .bus_re(bus_re), .bus_rdata(bus_rdata),
    .work_register(work_register), .flags(flags), .bit_fault(bit_fault));

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ends 1 ns after the taking edge, outputs settled
  task automatic instr(input logic [3:0] op, input logic [7:0] opd);
    int n;
    n = 0;
    @(posedge clk_sys);
    instr_valid   <= 1'b1;
    instr_op      <= op;
    instr_operand <= opd;
    @(negedge clk_sys);
    while (instr_ready !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 8) begin
      error_cnt++;
      end_of_test();
    end
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic set_in(input logic [7:0] io, input logic [15:0] t,
                        input logic [2:0] b);
    @(posedge clk_sys);
    io_rdata    <= io;
    timer_count <= t;
    instr_bit   <= b;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_we    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= v;
    @(posedge clk_sys);
    bus_we <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    bus_re   <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_re <= 1'b0;
    #1;
    v = bus_rdata;
  endtask

  task automatic ck(input logic [7:0] w, input logic [3:0] f);
    `CHK(work_register, w)
    `CHK(flags, f)
  endtask

  task automatic next_cycle();
    @(posedge clk_sys);
    #1;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    ck(8'h00, 4'h0);
    `CHK(instr_ready, 1'b1)
    // flags written by software persist through every transfer, except zero, which direct memory and IO loads update
    bus_wr(`DTU_REG_FLAGS, 8'h0e);
    bus_rd(`DTU_REG_FLAGS, d);
    `CHK(d, 8'h0e)
    bus_wr(`DTU_REG_WORK, 8'h3c);
    bus_rd(`DTU_REG_WORK, d);
    `CHK(d, 8'h3c)
    `CHK(work_register, 8'h3c)
    bus_rd(8'h07, d);
    `CHK(d, 8'h00)
    next_cycle();
    `CHK(bus_rdata, 8'h00)
    instr(imm, 8'h5a);
    ck(8'h5a, 4'he);
    `CHK(instr_ready, 1'b1)
    instr(st, 8'h10);
    ck(8'h5a, 4'he);
    instr(imm, 8'h00);
    ck(8'h00, 4'he);
    instr(st, 8'h11);
    instr(ld, 8'h10);
    ck(8'h5a, 4'he);
    instr(ld, 8'h11);
    ck(8'h00, 4'hf);
    set_in(8'h81, 16'hbeef, 3'h7);
    instr(ioi, 8'h22);
    ck(8'h81, 4'he);
    instr(ioo, 8'h2c);
    `CHK({io_we, io_port_byte, io_wdata}, 17'h12c81)
    ck(8'h81, 4'he);
    next_cycle();
    `CHK(io_we, 1'b0)
    set_in(8'h00, 16'hbeef, 3'h7);
    instr(ioi, 8'h23);
    ck(8'h00, 4'hf);
    // word to timer, low byte first
    instr(imm, 8'h34);
    instr(st, 8'h20);
    instr(imm, 8'h12);
    instr(st, 8'h21);
    instr(wt, 8'h20);
    `CHK({timer_load, timer_load_value}, 17'h11234)
    ck(8'h12, 4'hf);
    next_cycle();
    `CHK(timer_load, 1'b0)
    instr(tw, 8'h30);
    ck(8'h12, 4'hf);
    instr(ld, 8'h30);
    `CHK(work_register, 8'hef)
    instr(ld, 8'h31);
    `CHK(work_register, 8'hbe)
    // pointer word at 0x40, upper byte kept zero
    instr(imm, 8'h5b);
    instr(st, 8'h40);
    instr(imm, 8'h00);
    instr(st, 8'h41);
    instr(imm, 8'ha5);
    instr(xs, 8'h40);
    `CHK(instr_ready, 1'b0)
    next_cycle();
    ck(8'ha5, 4'he);
    instr(imm, 8'h00);
    instr(ld, 8'h5b);
    `CHK(work_register, 8'ha5)
    instr(imm, 8'h11);
    instr(xl, 8'h40);
    `CHK(instr_ready, 1'b0)
    next_cycle();
    ck(8'ha5, 4'he);
    `CHK(instr_ready, 1'b1)
    // highest legal bit address, then one past it
    instr(imm, 8'h00);
    instr(st, 8'h3f);
    instr(bs, 8'h3f);
    next_cycle();
    `CHK(bit_fault, 1'b0)
    instr(ld, 8'h3f);
    `CHK(work_register, 8'h80)
    instr(bc, 8'h3f);
    instr(ld, 8'h3f);
    `CHK(work_register, 8'h00)
    // out of range set must leave the pointer byte alone
    instr(bs, 8'h40);
    next_cycle();
    `CHK(bit_fault, 1'b1)
    instr(ld, 8'h40);
    `CHK(work_register, 8'h5b)
    bus_rd(`DTU_REG_STATUS, d);
    `CHK(d[`DTU_STAT_FAULT], 1'b1)
    bus_wr(`DTU_REG_STATUS, 8'h01);
    bus_rd(`DTU_REG_STATUS, d);
    `CHK(d, 8'h00)
    end_of_test();
  end
endmodule // data_transfer_instruction_unit_tb

// [verilog/data_transfer_instruction_unit.sv]
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "dtu_params.svh"

// Overview of operation
// - zero flag set when result is zero
// - carry flag holds unsigned carry or borrow
// - nibble flag holds low nibble carry
// - signed flag marks signed byte overflow
// - bit access only at addresses 0..63
// - immediate into work register, flags kept
// - work register to memory, flags kept
// - memory to work register, zero updated
// - IO to work register, zero updated
// - work register to IO, flags kept
// - timer count to memory word at once
// - memory word to timer count at once
// - indirect load, two cycles, flags kept
// - indirect store, two cycles, flags kept
module data_transfer_instruction_unit #(
  parameter int AW = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        instr_valid,
  input  wire logic [3:0]  instr_op,
  input  wire logic [7:0]  instr_operand,
  input  wire logic [2:0]  instr_bit,
  output logic             instr_ready,
  input  wire logic [7:0]  io_rdata,
  output logic [7:0]       io_port_byte,
  output logic [7:0]       io_wdata,
  output logic             io_we,
  input  wire logic [15:0] timer_count,
  output logic             timer_load,
  output logic [15:0]      timer_load_value,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_we,
  input  wire logic        bus_re,
  output logic [7:0]       bus_rdata,
  output logic [7:0]       work_register,
  output logic [3:0]       flags,
  output logic             bit_fault
);

  if (AW < 6 || AW > 8) begin : g_aw_check
    $error("AW must lie between 6 and 8");
  end

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  function automatic logic [7:0] put_bit(input logic [7:0] v,
                                         input logic [2:0] n,
                                         input logic       b);
    logic [7:0] r;
    r = v;
    r[n] = b;
    return r;
  endfunction

  dtu_pkg::state_t state;
  dtu_pkg::state_t next_state;
  logic [7:0]      ptr;
  logic            idx_store;

  wire dtu_pkg::op_t op = dtu_pkg::op_t'(instr_op);
  wire accept = instr_valid && instr_ready;
  wire in_idx = state == dtu_pkg::ST_IDX;

  wire do_imm   = accept && op == dtu_pkg::OP_MOV_A_IMM;
  wire do_st_m  = accept && op == dtu_pkg::OP_MOV_M_A;
  wire do_ld_m  = accept && op == dtu_pkg::OP_MOV_A_M;
  wire do_io_rd = accept && op == dtu_pkg::OP_MOV_A_IO;
  wire do_io_wr = accept && op == dtu_pkg::OP_MOV_IO_A;
  wire do_ldt   = accept && op == dtu_pkg::OP_TIMER_COUNT_TO_WORD;
  wire do_stt   = accept && op == dtu_pkg::OP_WORD_TO_TIMER_COUNT;
  wire do_idx   = accept && (op == dtu_pkg::OP_IDX_LD ||
                             op == dtu_pkg::OP_IDX_ST);
  wire is_bitop = op == dtu_pkg::OP_BIT_SET || op == dtu_pkg::OP_BIT_CLR;

  wire bit_ok   = instr_operand <= `DTU_BIT_ADDR_MAX;
  wire do_bit   = accept && is_bitop && bit_ok;
  wire bad_bit  = accept && is_bitop && !bit_ok;

  wire bus_w_work  = bus_we && bus_addr == `DTU_REG_WORK;
  wire bus_w_flags = bus_we && bus_addr == `DTU_REG_FLAGS;
  wire bus_w_stat  = bus_we && bus_addr == `DTU_REG_STATUS;

  // memory port selection
  logic [7:0] rd_lo;
  logic [7:0] rd_hi;
  wire [AW-1:0] op_addr = instr_operand[AW-1:0];
  wire [AW-1:0] ptr_addr = ptr[AW-1:0];
  wire [AW-1:0] mem_addr = in_idx ? ptr_addr : op_addr;

  wire idx_wr = in_idx && idx_store;
  wire idx_rd = in_idx && !idx_store;

  wire we_lo = do_st_m || do_ldt || do_bit || idx_wr;
  wire we_hi = do_ldt;
  wire [7:0] wd_lo = do_ldt ? timer_count[7:0] :
                     do_bit ? put_bit(rd_lo, instr_bit,
                                      op == dtu_pkg::OP_BIT_SET) :
                     work_register;
  wire [7:0] wd_hi = timer_count[15:8];

  dtu_data_ram #(
    .AW (AW)
  ) dtu_data_ram_inst (
    .clk_sys (clk_sys),
    .rd_addr (mem_addr),
    .rd_lo   (rd_lo),
    .rd_hi   (rd_hi),
    .wr_addr (mem_addr),
    .wd_lo   (wd_lo),
    .wd_hi   (wd_hi),
    .we_lo   (we_lo),
    .we_hi   (we_hi)
  );

  // work register and flags
  wire load_mem = do_ld_m || idx_rd;
  wire [7:0] next_work =
    do_imm   ? instr_operand :
    load_mem ? rd_lo :
    do_io_rd ? io_rdata :
    bus_w_work ? bus_wdata :
    work_register;

  wire next_zero =
    do_ld_m  ? is_zero(rd_lo) :
    do_io_rd ? is_zero(io_rdata) :
    bus_w_flags ? bus_wdata[`DTU_FLAG_ZERO] :
    flags[`DTU_FLAG_ZERO];

  wire next_carry = bus_w_flags ? bus_wdata[`DTU_FLAG_CARRY] :
                                  flags[`DTU_FLAG_CARRY];
  wire next_nibble = bus_w_flags ? bus_wdata[`DTU_FLAG_NIBBLE] :
                                   flags[`DTU_FLAG_NIBBLE];
  wire next_signed = bus_w_flags ? bus_wdata[`DTU_FLAG_SIGNED] :
                                   flags[`DTU_FLAG_SIGNED];

  wire [3:0] next_flags = {next_signed, next_nibble,
                           next_carry, next_zero};

  // set wins over a clear in the same cycle
  wire next_fault = bad_bit ||
    (bit_fault && !(bus_w_stat && bus_wdata[`DTU_STAT_FAULT]));

  wire [7:0] stat_word = {6'h00, !instr_ready, bit_fault};
  wire [7:0] next_rdata =
    !bus_re ? 8'h00 :
    bus_addr == `DTU_REG_WORK   ? work_register :
    bus_addr == `DTU_REG_FLAGS  ? {4'h0, flags} :
    bus_addr == `DTU_REG_STATUS ? stat_word :
    8'h00;

  always_comb begin
    case (state)
      dtu_pkg::ST_IDLE: next_state = do_idx ? dtu_pkg::ST_IDX
                                            : dtu_pkg::ST_IDLE;
      dtu_pkg::ST_IDX:  next_state = dtu_pkg::ST_IDLE;
      default:          next_state = dtu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= dtu_pkg::ST_IDLE;
      instr_ready <= 1'b1;
      ptr         <= `DTU_PTR_RST;
      idx_store   <= 1'b0;
    end else begin
      state       <= next_state;
      instr_ready <= next_state == dtu_pkg::ST_IDLE;
      if (do_idx) begin
        ptr       <= rd_lo;
        idx_store <= op == dtu_pkg::OP_IDX_ST;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      work_register <= `DTU_WORK_RST;
      flags         <= `DTU_FLAGS_RST;
      bit_fault     <= 1'b0;
      bus_rdata     <= `DTU_RDATA_RST;
    end else begin
      work_register <= next_work;
      flags         <= next_flags;
      bit_fault     <= next_fault;
      bus_rdata     <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      io_port_byte <= `DTU_IO_RST;
      io_wdata     <= `DTU_IO_RST;
      io_we        <= 1'b0;
    end else begin
      io_we <= do_io_wr;
      if (do_io_wr) begin
        io_port_byte <= instr_operand;
        io_wdata     <= work_register;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      timer_load       <= 1'b0;
      timer_load_value <= `DTU_TIMER_RST;
    end else begin
      timer_load <= do_stt;
      if (do_stt) begin
        timer_load_value <= {rd_hi, rd_lo};
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_imm;
    do_imm && !bus_w_flags |=> work_register == $past(instr_operand)
                               && $stable(flags);
  endproperty
  a_imm: assert property (p_imm)
    else $error("immediate load wrong");

  property p_st_m;
    do_st_m && !bus_w_flags |=> $stable(flags);
  endproperty
  a_st_m: assert property (p_st_m)
    else $error("memory store changed flags");

  property p_ld_m;
    do_ld_m && !bus_w_flags
      |=> flags[`DTU_FLAG_ZERO] == (work_register == 8'h00)
                && flags[3:1] == $past(flags[3:1]);
  endproperty
  a_ld_m: assert property (p_ld_m)
    else $error("memory load zero flag wrong");

  property p_io_rd;
    do_io_rd |=> work_register == $past(io_rdata) &&
                 flags[`DTU_FLAG_ZERO] == ($past(io_rdata) == 8'h00);
  endproperty
  a_io_rd: assert property (p_io_rd)
    else $error("io load wrong");

  property p_io_wr;
    do_io_wr |=> io_we && io_wdata == $past(work_register)
                 && io_port_byte == $past(instr_operand)
                 ##1 io_we == $past(do_io_wr);
  endproperty
  a_io_wr: assert property (p_io_wr)
    else $error("io write strobe wrong");

  property p_ldt;
    do_ldt |-> we_lo && we_hi && mem_addr == op_addr
               && wd_lo == timer_count[7:0]
               && wd_hi == timer_count[15:8];
  endproperty
  a_ldt: assert property (p_ldt)
    else $error("timer word not written whole");

  property p_stt;
    do_stt |=> timer_load && timer_load_value[7:0] == $past(rd_lo)
               && timer_load_value[15:8] == $past(rd_hi);
  endproperty
  a_stt: assert property (p_stt)
    else $error("timer load wrong");

  property p_idx_time;
    do_idx |=> !instr_ready && in_idx ##1 instr_ready && !in_idx;
  endproperty
  a_idx_time: assert property (p_idx_time)
    else $error("indirect access not two cycles");

  property p_idx_st;
    do_idx && op == dtu_pkg::OP_IDX_ST && !bus_w_flags
      |=> we_lo && mem_addr == AW'($past(rd_lo)) && $stable(flags);
  endproperty
  a_idx_st: assert property (p_idx_st)
    else $error("indirect store wrong");

  property p_bit;
    accept && is_bitop && instr_operand > `DTU_BIT_ADDR_MAX
      |-> !we_lo ##1 bit_fault;
  endproperty
  a_bit: assert property (p_bit)
    else $error("out of range bit access taken");

  property p_flags_held;
    !bus_w_flags |=> flags[3:1] == $past(flags[3:1]);
  endproperty
  a_flags_held: assert property (p_flags_held)
    else $error("carry group changed without software");

endmodule // data_transfer_instruction_unit

// [verilog/dtu_data_ram.sv]
`timescale 1ns/1ps

// byte memory, asynchronous read of a byte pair, paired write
module dtu_data_ram #(
  parameter int AW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_lo,
  output logic      [7:0]    rd_hi,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wd_lo,
  input  wire logic [7:0]    wd_hi,
  input  wire logic          we_lo,
  input  wire logic          we_hi
);

  logic [7:0] mem [0:(1<<AW)-1];

  wire [AW-1:0] rd_next = rd_addr + AW'(1);
  wire [AW-1:0] wr_next = wr_addr + AW'(1);

  assign rd_lo = mem[rd_addr];
  assign rd_hi = mem[rd_next];

  always_ff @(posedge clk_sys) begin
    if (we_lo) begin
      mem[wr_addr] <= wd_lo;
    end
    if (we_hi) begin
      mem[wr_next] <= wd_hi;
    end
  end

endmodule // dtu_data_ram

// [verilog/dtu_params.svh]
`ifndef DTU_PARAMS_SVH
`define DTU_PARAMS_SVH

// register port offsets
`define DTU_REG_WORK    8'h00
`define DTU_REG_FLAGS   8'h01
`define DTU_REG_STATUS  8'h02

// flag field positions inside the flag register
`define DTU_FLAG_ZERO   0
`define DTU_FLAG_CARRY  1
`define DTU_FLAG_NIBBLE 2
`define DTU_FLAG_SIGNED 3

// status field positions
`define DTU_STAT_FAULT  0
`define DTU_STAT_BUSY   1

// reset values
`define DTU_WORK_RST    8'h00
`define DTU_FLAGS_RST   4'h0
`define DTU_PTR_RST     8'h00
`define DTU_TIMER_RST   16'h0000
`define DTU_IO_RST      8'h00
`define DTU_RDATA_RST   8'h00

// highest byte address a single-bit access may name
`define DTU_BIT_ADDR_MAX 8'h3f

`endif

// [verilog/dtu_pkg.sv]
package dtu_pkg;

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_MOV_A_IMM = 4'h1,
    OP_MOV_M_A   = 4'h2,
    OP_MOV_A_M   = 4'h3,
    OP_MOV_A_IO  = 4'h4,
    OP_MOV_IO_A  = 4'h5,
    OP_TIMER_COUNT_TO_WORD     = 4'h6,
    OP_WORD_TO_TIMER_COUNT     = 4'h7,
    OP_IDX_LD    = 4'h8,
    OP_IDX_ST    = 4'h9,
    OP_BIT_SET   = 4'ha,
    OP_BIT_CLR   = 4'hb
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_IDX  = 1'b1
  } state_t;

endpackage
